/* core/dcp_config_port.sv */
// Notes on behaviour
// R1 - Host writes land in a buffer; core sees only latched working copy.
// R2 - Update toggle or profile pin change copies whole buffer at once.
// R3 - Mode pin picks parallel bus or serial port for programming.
// R4 - Profile registers read from bank chosen by profile pins.
// R5 - Parallel port: eight data lines, six address, low read and write.
// R6 - Controller pulses one strobe, never both together.
// R7 - One parallel write stores one byte at its address.
// R8 - Parallel reads are slow debug access; controller allows long reads.
// R9 - Serial port: low select, clock, high resync, one or two data lines.
// R10 - Two-wire mode: data pin carries both directions, output pin idle.
// R11 - Three-wire mode: data pin input only, reads leave on output pin.
// R12 - Instruction byte: top bit read flag, bit six ignored, six address.
// R13 - Data phase moves every byte of the addressed register.
// R14 - Serial write bits captured on rising serial clock.
// R15 - Serial read bits launched on falling serial clock.
// R16 - Control bit selects MSB or LSB first for both phases.
// R17 - Select high floats both serial data pins; low makes them active. Code drives one only: out pin in 3-wire, data pin on 2-wire reads.
// R18 - Controller selects only one device on a shared bus.
// R19 - Resync aborts transfer; next eight clocks form an instruction.
// R20 - Resync leaves already written contents untouched.
// R21 - Sync clock output is core clock divided by eight.
// R22 - Update and profile pins sampled on rising sync clock edges.
// R23 - Parallel data driven only while read strobe is low.
// R24 - Select high restarts bit counting at instruction phase.
module dcp_config_port
    import dcp_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 port_mode_pin,
    input  wire logic [ADDR_W-1:0]    parAddr,
    input  wire logic [7:0]           parDataIn,
    output logic      [7:0]           parDataOut,
    output logic                      parDataOe,
    input  wire logic                 parReadN,
    input  wire logic                 parWriteN,
    input  wire logic                 serSelectN,
    input  wire logic                 serClk,
    input  wire logic                 serial_resync,
    input  wire logic                 serDataIn,
    output logic                      serDataOut,
    output logic                      serDataOe,
    output logic                      serOutPin,
    output logic                      serOutOe,
    input  wire logic                 update_strobe,
    input  wire logic                 profile_sel_lo,
    input  wire logic                 profile_sel_hi,
    output logic                      divided_sync_clock,
    output logic [WORK_BYTES*8-1:0]   workRegs,
    output logic [1:0]                activeProfile
);
    import dcp_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [1:0] serLen(input logic [5:0] a);
        logic [1:0] n;
        n = SER_LEN_DEF;
        unique case (a)
            SER_A_CTRL, SER_A_DELTA, SER_A_TUNE: n = SER_LEN_FOUR;
            SER_A_RAMP:                          n = SER_LEN_TWO;
            default:                             n = SER_LEN_DEF;
        endcase
        return n;
    endfunction

    function automatic logic [5:0] serBase(input logic [5:0] a);
        logic [5:0] b;
        b = BASE_NONE;
        unique case (a)
            SER_A_CTRL:  b = CTRL_ADDR;
            SER_A_DELTA: b = BASE_DELTA;
            SER_A_RAMP:  b = BASE_RAMP;
            SER_A_TUNE:  b = PROF_BASE;
            default:     b = BASE_NONE;
        endcase
        return b;
    endfunction

    function automatic int bufIndex(input logic [5:0] a,
                                    input logic [1:0] p);
        int i;
        i = int'(a);
        if (a >= PROF_BASE && a <= PROF_LAST && p != 2'h0) begin
            i = BUF_BYTES + (int'(p) - 1) * PROF_BYTES
                + int'(a - PROF_BASE);
        end
        return i;
    endfunction

    // ---------------------------------------------------------------
    // Sync clock and update sampling
    // ---------------------------------------------------------------
    logic [2:0] divCnt_q;
    logic       syncClk_q;
    logic       syncRise;
    logic       updSamp_q;
    logic [1:0] profSamp_q;
    logic       doUpdate;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divCnt_q  <= 3'h0;
            syncClk_q <= 1'b0;
        end else begin
            divCnt_q <= divCnt_q + 3'h1;
            if (divCnt_q == SYNC_HALF || divCnt_q == BIT_LAST) begin
                syncClk_q <= ~syncClk_q; // see R21
            end
        end
    end

    assign divided_sync_clock = syncClk_q;
    assign syncRise = (divCnt_q == SYNC_HALF) && !syncClk_q; // see R22

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            updSamp_q  <= 1'b0;
            profSamp_q <= 2'h0;
        end else if (syncRise) begin
            updSamp_q  <= update_strobe; // see R22
            profSamp_q <= {profile_sel_hi, profile_sel_lo}; // see R22
        end
    end

    assign doUpdate = syncRise
        && ((update_strobe != updSamp_q)
            || ({profile_sel_hi, profile_sel_lo} != profSamp_q)); // see R2

    assign activeProfile = profSamp_q;

    // ---------------------------------------------------------------
    // Serial edge detection
    // ---------------------------------------------------------------
    logic sclk_q;
    logic csn_q;
    logic sRise;
    logic sFall;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            csn_q  <= 1'b1;
        end else begin
            sclk_q <= serClk;
            csn_q  <= serSelectN;
        end
    end

    assign sRise = serClk && !sclk_q;
    assign sFall = !serClk && sclk_q;

    // ---------------------------------------------------------------
    // Buffer and serial engine
    // ---------------------------------------------------------------
    logic [7:0]     buf_q [WORK_BYTES];
    logic [7:0]     work_q [WORK_BYTES];
    dcp_ser_state_t st_q;
    logic [2:0]     bitCnt_q;
    logic [7:0]     shift_q;
    logic [7:0]     txByte_q;
    logic           isRead_q;
    logic [5:0]     byteAddr_q;
    logic [1:0]     bytesLeft_q;
    logic           txBit_q;
    logic           lsbFirst;
    logic           threeWire;
    logic [7:0]     rxByte;
    logic           serActive;
    logic           parWrite;
    logic           serAbort;
    logic           serStep;
    logic           lastBit;
    logic           serWrite;

    assign lsbFirst  = buf_q[CTRL_ADDR][CTRL_LSB_BIT];
    assign threeWire = buf_q[CTRL_ADDR][CTRL_3W_BIT];
    // see R9
    assign serActive = !port_mode_pin && !serSelectN && !serial_resync;
    assign rxByte    = lsbFirst ? {serDataIn, shift_q[7:1]}
                                : {shift_q[6:0], serDataIn}; // see R16
    assign parWrite  = port_mode_pin && !parWriteN && parReadN; // see R6

    assign serAbort = serial_resync || serSelectN || port_mode_pin;
    assign serStep  = !serAbort && sRise && st_q != SER_DONE;
    assign lastBit  = bitCnt_q == BIT_LAST;
    assign serWrite = serStep && st_q == SER_DATA && lastBit && !isRead_q
                      && byteAddr_q != BASE_NONE;

    // ---------------------------------------------------------------
    // Serial state
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= SER_INSTR;
        end else if (serAbort) begin
            st_q <= SER_INSTR; // see R19, R24
        end else if (serStep && lastBit) begin
            if (st_q == SER_INSTR) begin
                st_q <= SER_DATA;
            end else if (bytesLeft_q == 2'h0) begin
                st_q <= SER_DONE; // see R13
            end
        end
    end

    // ---------------------------------------------------------------
    // Serial bit counter
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bitCnt_q <= 3'h0;
        end else if (serAbort) begin
            bitCnt_q <= 3'h0; // see R19, R24
        end else if (serStep) begin
            bitCnt_q <= bitCnt_q + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // Serial shift register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_q <= 8'h00;
        end else if (serStep) begin
            shift_q <= rxByte; // see R14
        end
    end

    // ---------------------------------------------------------------
    // Instruction fields and byte pointer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            isRead_q    <= 1'b0;
            byteAddr_q  <= 6'h00;
            bytesLeft_q <= 2'h0;
        end else if (serStep && lastBit) begin
            if (st_q == SER_INSTR) begin
                isRead_q    <= rxByte[INS_RD_BIT]; // see R12
                byteAddr_q  <= serBase(rxByte[ADDR_W-1:0]);
                bytesLeft_q <= serLen(rxByte[ADDR_W-1:0]);
            end else if (bytesLeft_q != 2'h0) begin
                bytesLeft_q <= bytesLeft_q - 2'h1; // see R13
                byteAddr_q  <= byteAddr_q + 6'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Host buffer
    // ---------------------------------------------------------------

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < WORK_BYTES; i++) begin
                buf_q[i] <= 8'h00;
            end
            buf_q[CTRL_ADDR] <= CTRL_RESET;
        end else if (parWrite) begin
            buf_q[bufIndex(parAddr, profSamp_q)] <= parDataIn; // see R7, R1
        end else if (serWrite) begin
            buf_q[bufIndex(byteAddr_q, profSamp_q)] <= rxByte; // see R1, R20
        end
    end

    // ---------------------------------------------------------------
    // Working copy
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < WORK_BYTES; i++) begin
                work_q[i] <= 8'h00;
            end
            work_q[CTRL_ADDR] <= CTRL_RESET;
        end else if (doUpdate) begin
            for (int i = 0; i < WORK_BYTES; i++) begin
                work_q[i] <= buf_q[i]; // see R2
            end
        end
    end

    always_comb begin
        for (int i = 0; i < WORK_BYTES; i++) begin
            workRegs[i*8 +: 8] = work_q[i];
        end
    end

    // ---------------------------------------------------------------
    // Serial readback
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txByte_q <= 8'h00;
            txBit_q  <= 1'b0;
        end else if (!serActive || st_q != SER_DATA) begin
            txByte_q <= buf_q[bufIndex(serBase(rxByte[ADDR_W-1:0]),
                                       profSamp_q)];
            txBit_q  <= 1'b0;
        end else if (sFall && isRead_q) begin
            txBit_q <= lsbFirst ? txByte_q[bitCnt_q]
                                : txByte_q[BIT_LAST - bitCnt_q]; // see R15, R4
            if (bitCnt_q == BIT_LAST) begin
                txByte_q <= buf_q[bufIndex(byteAddr_q + 6'h01, profSamp_q)];
            end
        end
    end

    assign serDataOut = txBit_q;
    assign serOutPin  = txBit_q;

    // ---------------------------------------------------------------
    // Serial output enables
    // ---------------------------------------------------------------
    // see R17, R10, R11
    assign serDataOe  = serActive && !threeWire && isRead_q
                        && st_q == SER_DATA;
    assign serOutOe   = !port_mode_pin && !serSelectN && threeWire;

    // ---------------------------------------------------------------
    // Parallel readback
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            parDataOut <= 8'h00;
        end else begin
            parDataOut <= buf_q[bufIndex(parAddr, profSamp_q)]; // see R4, R8
        end
    end

    assign parDataOe = port_mode_pin && !parReadN; // see R23, R3, R5

    logic unusedCsn;
    assign unusedCsn = csn_q;
endmodule

/* shared/dcp_pkg.sv */
package dcp_pkg;
    // ---------------------------------------------------------------
    // Buffer geometry
    // ---------------------------------------------------------------
    localparam int          ADDR_W       = 6;
    localparam int          BUF_BYTES    = 64;
    localparam int          PROF_BYTES   = 4;
    localparam int          PROF_COUNT   = 4;
    localparam int          WORK_BYTES   = BUF_BYTES + PROF_BYTES * 3;
    localparam logic [5:0]  PROF_BASE    = 6'h0A;
    localparam logic [5:0]  PROF_LAST    = 6'h0D;

    // ---------------------------------------------------------------
    // Control byte fields and reset value
    // ---------------------------------------------------------------
    localparam logic [5:0]  CTRL_ADDR    = 6'h00;
    localparam int          CTRL_LSB_BIT = 0;
    localparam int          CTRL_3W_BIT  = 1;
    localparam logic [7:0]  CTRL_RESET   = 8'h18;

    // ---------------------------------------------------------------
    // Serial instruction fields
    // ---------------------------------------------------------------
    localparam int          INS_RD_BIT   = 7;
    localparam logic [2:0]  BIT_LAST     = 3'h7;

    // ---------------------------------------------------------------
    // Serial register lengths (bytes) by serial address
    // ---------------------------------------------------------------
    localparam int          SER_REGS     = 16;
    localparam logic [1:0]  SER_LEN_DEF  = 2'h0;
    localparam logic [1:0]  SER_LEN_FOUR = 2'h3;
    localparam logic [1:0]  SER_LEN_TWO  = 2'h1;
    localparam logic [5:0]  SER_A_CTRL   = 6'h00;
    localparam logic [5:0]  SER_A_DELTA  = 6'h01;
    localparam logic [5:0]  SER_A_RAMP   = 6'h02;
    localparam logic [5:0]  SER_A_TUNE   = 6'h03;
    localparam logic [5:0]  BASE_DELTA   = 6'h04;
    localparam logic [5:0]  BASE_RAMP    = 6'h08;
    localparam logic [5:0]  BASE_NONE    = 6'h3F;

    // ---------------------------------------------------------------
    // Sync clock divider
    // ---------------------------------------------------------------
    localparam int          SYNC_DIV     = 8;
    localparam logic [2:0]  SYNC_HALF    = 3'h3;

    typedef enum logic [1:0] {
        SER_INSTR,
        SER_DATA,
        SER_DONE
    } dcp_ser_state_t;
endpackage

/* test/dcp_config_port_chk.sv */
module dcp_config_port_chk
    import dcp_pkg::*;
(
    input wire logic                    clk_sys,
    input wire logic                    rst,
    input wire logic                    port_mode_pin,
    input wire logic                    parReadN,
    input wire logic                    serSelectN,
    input wire logic                    parDataOe,
    input wire logic                    serDataOe,
    input wire logic                    serOutOe,
    input wire logic                    divided_sync_clock,
    input wire logic [WORK_BYTES*8-1:0] workRegs,
    input wire logic [1:0]              activeProfile
);
    // ----------------------
    // Port timing checks
    // ----------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_PAR_OE: assert property (
        parDataOe == (port_mode_pin && !parReadN))
        else $error("parallel enable wrong");
    AST_SER_HIZ: assert property (
        serSelectN |-> !serDataOe && !serOutOe)
        else $error("serial pins driven while deselected");
    AST_SYNC_PER: assert property (
        $rose(divided_sync_clock) |-> ##8 $rose(divided_sync_clock))
        else $error("sync clock period wrong");
    AST_SYNC_HI: assert property (
        $rose(divided_sync_clock) |->
        divided_sync_clock [*4] ##1 !divided_sync_clock)
        else $error("sync clock duty wrong");
    AST_WORK_GAP: assert property (
        !$stable(workRegs) |=> $stable(workRegs) [*7])
        else $error("working copy updated off sync");
    AST_PROF_GAP: assert property (
        !$stable(activeProfile) |=> $stable(activeProfile) [*7])
        else $error("profile sampled off sync");
    AST_PAR_MODE: assert property (
        port_mode_pin |-> !serOutOe)
        else $error("serial output active in parallel mode");
    AST_ONE_WIRE: assert property (
        !(serDataOe && serOutOe))
        else $error("both serial outputs driven");

    cover property ($rose(serDataOe));
    cover property ($rose(serOutOe));
    cover property (!$stable(workRegs));
endmodule

bind dcp_config_port dcp_config_port_chk dcp_config_port_chk_i (
    .clk_sys, .rst, .port_mode_pin, .parReadN, .serSelectN, .parDataOe,
    .serDataOe, .serOutOe, .divided_sync_clock, .workRegs, .activeProfile);

/* test/dcp_host_model.sv */
module dcp_host_model (
    input  wire logic clk,
    input  wire logic sdio,
    input  wire logic sdo,
    output logic      selN,
    output logic      sclk,
    output logic      sd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        selN = 1'h1;
        sclk = 1'h0;
        sd = 1'h1;
    end
    // Select only this target, then settle
    task automatic sel(input logic s);
        @(negedge clk);
        selN = s;
        repeat (2) @(negedge clk);
    endtask
    // Bits MSB first, data set on falling clock
    task automatic xfer(input logic [7:0] tx, input int n,
                        input logic drv, w3, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            @(negedge clk);
            sclk = 1'h0;
            sd = drv ? tx[i] : ~sd;
            repeat (3) @(negedge clk);
            rx[i] = w3 ? sdo : sdio;
            sclk = 1'h1;
            repeat (2) @(negedge clk);
        end
        @(negedge clk);
        sclk = 1'h0;
    endtask
endmodule

/* test/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dcp_pkg::*;
    logic        clk_sys, rst, modeP, rdN, wrN, upd, psLo, psHi, resync;
    logic [5:0]  addr;
    logic [7:0]  din, pdo, rx;
    logic        pdoe, sdOut, sdOe, soPin, soOe, dsc;
    logic [1:0]  actP;
    logic [WORK_BYTES*8-1:0] work;
    wire         selN, sclk, hostD, sdio;
    int          errCount, testsRun;

    assign sdio = sdOe ? sdOut : hostD;
    dcp_config_port dcp_config_port_i (.clk_sys(clk_sys), .rst(rst),
        .port_mode_pin(modeP), .parAddr(addr), .parDataIn(din),
        .parDataOut(pdo), .parDataOe(pdoe), .parReadN(rdN),
        .parWriteN(wrN), .serSelectN(selN), .serClk(sclk),
        .serial_resync(resync), .serDataIn(sdio), .serDataOut(sdOut),
        .serDataOe(sdOe), .serOutPin(soPin), .serOutOe(soOe),
        .update_strobe(upd), .profile_sel_lo(psLo),
        .profile_sel_hi(psHi), .divided_sync_clock(dsc),
        .workRegs(work), .activeProfile(actP));
    dcp_host_model host_i (.clk(clk_sys), .sdio(sdio), .sdo(soPin),
        .selN(selN), .sclk(sclk), .sd(hostD));

    task automatic chk8(input string n, input logic [7:0] e, g);
        testsRun++;
        if (g !== e) begin
            errCount++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] wb(input int i);
        return work[8*i +: 8];
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic updt;
        upd = ~upd;
        cyc(20);
    endtask
    task automatic pwr(input logic [5:0] a, input logic [7:0] d);
        cyc(1);
        addr = a;
        din = d;
        wrN = 1'h0;
        cyc(1);
        wrN = 1'h1;
    endtask
    task automatic prd(input logic [5:0] a, input logic [7:0] e);
        cyc(1);
        addr = a;
        rdN = 1'h0;
        cyc(3);
        chk8("rdOe", 8'h01, {7'h00, pdoe});
        chk8("rdData", e, pdo);
        rdN = 1'h1;
        cyc(1);
        chk8("rdOff", 8'h00, {7'h00, pdoe});
    endtask
    // ----------------------
    // Scenarios
    // ----------------------
    task automatic t_par;
        chk8("rstCtrl", 8'h18, wb(0));
        pwr(6'h04, 8'h5A);
        prd(6'h04, 8'h5A);
        chk8("held", 8'h00, wb(4));
        updt;
        chk8("updated", 8'h5A, wb(4));
    endtask
    task automatic t_prof;
        psLo = 1'h1;
        cyc(20);
        chk8("prof", 8'h01, {6'h00, actP});
        pwr(6'h0A, 8'hC3);
        prd(6'h0A, 8'hC3);
        updt;
        chk8("bank1", 8'hC3, wb(64));
        pwr(6'h05, 8'h11);
        psLo = 1'h0;
        cyc(20);
        chk8("profUpd", 8'h11, wb(5));
        chk8("bank0", 8'h00, wb(10));
        psHi = 1'h1;
        cyc(20);
        chk8("prof2", 8'h02, {6'h00, actP});
        pwr(6'h0B, 8'h77);
        prd(6'h0B, 8'h77);
        updt;
        chk8("bank2", 8'h77, wb(69));
        psHi = 1'h0;
        cyc(20);
        chk8("prof0", 8'h00, {6'h00, actP});
    endtask
    task automatic t_ser_wr;
        modeP = 1'h0;
        host_i.sel(1'h0);
        host_i.xfer(8'h01, 8, 1'h1, 1'h0, rx);
        repeat (4) host_i.xfer(8'h96, 8, 1'h1, 1'h0, rx);
        host_i.sel(1'h1);
        updt;
        for (int i = 4; i < 8; i++) chk8("serWr", 8'h96, wb(i));
    endtask
    task automatic t_ser_rd(input logic w3);
        host_i.sel(1'h0);
        host_i.xfer(8'h81, 8, 1'h1, w3, rx);
        for (int i = 0; i < 4; i++) begin
            host_i.xfer(8'h00, 8, 1'h0, w3, rx);
            chk8("serRd", 8'h96, rx);
            if (i == 0) begin
                chk8("sdioOe", {7'h00, !w3}, {7'h00, sdOe});
                chk8("soOe", {7'h00, w3}, {7'h00, soOe});
            end
        end
        host_i.sel(1'h1);
        chk8("hiZ", 8'h00, {6'h00, sdOe, soOe});
    endtask
    task automatic t_resync;
        host_i.sel(1'h0);
        host_i.xfer(8'hFF, 3, 1'h1, 1'h0, rx);
        resync = 1'h1;
        cyc(2);
        resync = 1'h0;
        host_i.xfer(8'h02, 8, 1'h1, 1'h0, rx);
        repeat (2) host_i.xfer(8'h3C, 8, 1'h1, 1'h0, rx);
        host_i.sel(1'h1);
        updt;
        chk8("resyncLo", 8'h3C, wb(8));
        chk8("resyncHi", 8'h3C, wb(9));
        chk8("kept", 8'h96, wb(4));
    endtask
    task automatic t_3w;
        modeP = 1'h1;
        pwr(6'h00, 8'h1A);
        updt;
        modeP = 1'h0;
        cyc(2);
        t_ser_rd(1'h1);
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", errCount, testsRun);
        if (errCount == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        errCount++;
        close_out;
    end
    initial begin
        {rst, rdN, wrN, modeP} = 4'hF;
        {upd, psLo, psHi, resync} = 4'h0;
        addr = 6'h00;
        din = 8'h00;
        errCount = 0;
        testsRun = 0;
        repeat (20) @(posedge clk_sys);
        cyc(1);
        rst = 1'h0;
        t_par;
        t_prof;
        t_ser_wr;
        t_ser_rd(1'h0);
        t_resync;
        t_3w;
        close_out;
    end
endmodule
